/* File: hdl/dps_pkg.sv */
// constants and types shared by the display rail power sequencer
package dps_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS     = 1_000_000;

  // times as specified
  localparam int unsigned T_STEP_MS     = 2;
  localparam int unsigned T_RAIL_MS     = 2;
  localparam int unsigned T_SOFT_MS     = 10;
  localparam int unsigned T_WIN_NS      = 62_500;

  // derived cycle counts (window is a longest time, rounded down)
  localparam int unsigned STEP_CYC      = T_STEP_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned RAIL_CYC      = T_RAIL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned SOFT_CYC      = T_SOFT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned WIN_CYC       = T_WIN_NS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W         = 20;
  localparam int unsigned NUM_RAILS     = 4;

  // rail index = enable pin index, also default power-up order
  localparam int unsigned RAIL_NSRC     = 0;
  localparam int unsigned RAIL_NGATE    = 1;
  localparam int unsigned RAIL_PSRC     = 2;
  localparam int unsigned RAIL_PGATE    = 3;

  // mode output encoding
  localparam logic [1:0]  MODE_SLEEP    = 2'h0;
  localparam logic [1:0]  MODE_STANDBY  = 2'h1;
  localparam logic [1:0]  MODE_ACTIVE   = 2'h2;

  typedef enum logic [2:0] {
    ST_SLEEP   = 3'h0,
    ST_PWRUP   = 3'h1,
    ST_ACTIVE  = 3'h3,
    ST_PWRDN   = 3'h2,
    ST_STANDBY = 3'h6
  } dps_state_t;

  localparam dps_state_t  RST_STATE     = ST_SLEEP;

endpackage

/* File: hdl/dps_pin_sync.sv */
// two-stage synchroniser with edge detection for host control pins
`timescale 1ns/1ps
module dps_pin_sync #(
  parameter int unsigned W = 5
) (
  input  wire logic         clk_i,   // system clock
  input  wire logic         rst_i,   // synchronous reset, active high
  input  wire logic [W-1:0] pin_i,   // raw pin levels
  output logic      [W-1:0] level_o, // synchronised level
  output logic      [W-1:0] rise_o,  // one-cycle rising edge
  output logic      [W-1:0] fall_o   // one-cycle falling edge
);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= pin_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~prev;
  assign fall_o  = ~sync & prev;

endmodule

/* File: hdl/dps_sequencer.sv */
// mode controller and rail sequencer for a display power chip
// Behaviour
// - wake low means sleep, everything off
// - base faults: fixed power-down, then standby; here all rails drop at once, one cycle after the boost enable falls
// - active: pin fall off, pin rise on
// - wake rise, pin high: default power-up
// - wake rise, pins low: standby, rails off
// - wake fall in active: power-down, sleep
// - rails off in host lowering order
// - from standby rails on in raise order
// - wake fall, no rail: standby to sleep
// - rail regulates 2 ms after enable
// - power-good released only all rails regulating
// - pin to rail assignment fixed
// - all pins low, rails off: standby
// - boost waits for inverting converter good
// - rails gated by boost power good
// - positive source waits negative source good
// - rises within window staggered by good
// - simultaneous falls switch rails off together
// - default sequences step every 2 ms
// - base converter not good in 10 ms: abort
// - rail undervoltage kills rail and dependents
`timescale 1ns/1ps
module dps_sequencer
  import dps_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = dps_pkg::STEP_CYC,
  parameter int unsigned RAIL_CYCLES = dps_pkg::RAIL_CYC,
  parameter int unsigned SOFT_CYCLES = dps_pkg::SOFT_CYC,
  parameter int unsigned WIN_CYCLES  = dps_pkg::WIN_CYC
) (
  input  wire logic                           MCLK_I,             // 100 MHz clock
  input  wire logic                           RST_I,              // synchronous reset, active high
  input  wire logic                           WAKE_PIN_I,         // wake pin
  input  wire logic [dps_pkg::NUM_RAILS-1:0]  RAIL_ENABLE_PINS_I, // rail enable pins
  input  wire logic                           INPUT_INPUT_UNDERVOLTAGE_LOCKOUT_I,       // input undervoltage lockout
  input  wire logic                           POS_BOOST_UV_I,     // positive boost undervoltage
  input  wire logic                           INV_CONV_UV_I,      // inverting converter undervoltage
  input  wire logic                           THERMAL_SHUTDOWN_I, // thermal shutdown
  input  wire logic [dps_pkg::NUM_RAILS-1:0]  RAIL_UV_I,          // per-rail undervoltage
  input  wire logic                           INV_CONV_PG_I,      // inverting converter good
  input  wire logic                           POS_BOOST_PG_I,     // positive boost good
  output logic                                INV_CONV_EN_O,      // inverting converter enable
  output logic                                POS_BOOST_EN_O,     // positive boost enable
  output logic      [dps_pkg::NUM_RAILS-1:0]  RAIL_EN_O,          // rail enables
  output logic                                BIAS_EN_O,          // backplane bias driver enable
  output logic                                SUPPORT_ON_O,       // support circuitry powered
  output logic      [1:0]                     MODE_O,             // sleep, standby or active
  output logic                                RAILS_OK_O,         // open-drain data, always low
  output logic                                RAILS_OK_OE_N_O     // low while pulling pin low
);

  import dps_pkg::*;

  dps_state_t            state;
  logic [1:0]            seq_idx;
  logic [CNT_W-1:0]      step_cnt;
  logic                  down_to_sleep;
  logic [NUM_RAILS-1:0]  req;
  logic [NUM_RAILS-1:0]  grouped;
  logic [NUM_RAILS-1:0]  win_rails;
  logic [CNT_W-1:0]      win_cnt;
  logic [NUM_RAILS-1:0]  rail_en;
  logic [NUM_RAILS-1:0]  rail_reg;
  logic [NUM_RAILS-1:0]  next_rail_en;
  logic [NUM_RAILS-1:0]  uv_kill;
  logic [CNT_W-1:0]      rail_cnt [NUM_RAILS];
  logic [CNT_W-1:0]      soft_cnt;
  logic                  inv_en;
  logic                  pos_en;
  logic                  soft_abort;
  logic                  base_fault;
  logic                  step_first;
  logic                  step_done;
  logic                  host_ctl;
  logic [4:0]            pin_lvl;
  logic [4:0]            pin_rise;
  logic [4:0]            pin_fall;
  logic                  wake_lvl;
  logic                  wake_rise;
  logic [NUM_RAILS-1:0]  en_lvl;
  logic [NUM_RAILS-1:0]  en_rise;
  logic [NUM_RAILS-1:0]  en_fall;

  // rail i may start only once every grouped rail before it regulates
  function automatic logic stagger_ok(input int unsigned idx, input logic [NUM_RAILS-1:0] grp,
                                      input logic [NUM_RAILS-1:0] rq, input logic [NUM_RAILS-1:0] rg);
    logic ok;
    ok = 1'b1;
    for (int unsigned j = 0; j < NUM_RAILS; j++)
    begin
      if (j < idx && grp[j] && rq[j] && !rg[j])
        ok = 1'b0;
    end
    return ok;
  endfunction

  dps_pin_sync #(
    .W       (5)
  ) u_pin_sync (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .pin_i   ({WAKE_PIN_I, RAIL_ENABLE_PINS_I}),
    .level_o (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  assign wake_lvl   = pin_lvl[4];
  assign wake_rise  = pin_rise[4];
  assign en_lvl     = pin_lvl[3:0];
  assign en_rise    = pin_rise[3:0];
  assign en_fall    = pin_fall[3:0];

  assign base_fault = INPUT_INPUT_UNDERVOLTAGE_LOCKOUT_I | POS_BOOST_UV_I | INV_CONV_UV_I | THERMAL_SHUTDOWN_I;
  assign step_first = (step_cnt == '0);
  assign step_done  = (step_cnt == CNT_W'(STEP_CYCLES - 1));
  assign host_ctl   = (state == ST_STANDBY) || (state == ST_ACTIVE);
  assign soft_abort = (soft_cnt == CNT_W'(SOFT_CYCLES - 1));

  // undervoltage on a rail drops it; positive source depends on negative source
  always_comb
  begin
    uv_kill            = RAIL_UV_I & rail_en;
    uv_kill[RAIL_PSRC] = uv_kill[RAIL_PSRC] | uv_kill[RAIL_NSRC];
  end

  // mode state machine
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      state         <= RST_STATE;
      seq_idx       <= 2'h0;
      step_cnt      <= '0;
      down_to_sleep <= 1'b0;
    end
    else
    begin
      case (state)
        ST_SLEEP:
        begin
          step_cnt <= '0;
          seq_idx  <= 2'h0;
          if (wake_rise && |en_lvl)
            state <= ST_PWRUP;
          else if (wake_rise)
            state <= ST_STANDBY;
        end
        ST_STANDBY:
        begin
          if (!wake_lvl)
            state <= ST_SLEEP;
          else if (|en_rise)
            state <= ST_ACTIVE;
        end
        ST_PWRUP, ST_ACTIVE:
        begin
          if (!wake_lvl || base_fault || soft_abort)
          begin
            state         <= ST_PWRDN;
            down_to_sleep <= !wake_lvl;
            seq_idx       <= 2'(RAIL_PGATE);
            step_cnt      <= '0;
          end
          else if (state == ST_PWRUP)
          begin
            step_cnt <= step_done ? '0 : step_cnt + 1'b1;
            if (step_done && seq_idx == 2'(RAIL_PGATE))
              state <= ST_ACTIVE;
            else if (step_done)
              seq_idx <= seq_idx + 2'h1;
          end
          else if (req == '0 && rail_en == '0)
            state <= ST_STANDBY;
        end
        ST_PWRDN:
        begin
          if (!wake_lvl)
            down_to_sleep <= 1'b1;
          step_cnt <= step_done ? '0 : step_cnt + 1'b1;
          if (step_done && seq_idx == 2'(RAIL_NSRC))
          begin
            state         <= (down_to_sleep || !wake_lvl) ? ST_SLEEP : ST_STANDBY;
            down_to_sleep <= 1'b0;
          end
          else if (step_done)
            seq_idx <= seq_idx - 2'h1;
        end
        default:
          state <= RST_STATE;
      endcase
    end
  end

  // requested rails: set and cleared by edges in standby and active, set by pin level at each power-up step
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      req <= '0;
    else
    begin
      case (state)
        ST_STANDBY, ST_ACTIVE:
          req <= (req & ~en_fall & ~uv_kill) | en_rise;
        ST_PWRUP:
        begin
          req <= req & ~uv_kill;
          if (step_first && en_lvl[seq_idx])
            req[seq_idx] <= 1'b1;
        end
        ST_PWRDN:
        begin
          req <= req & ~uv_kill;
          if (step_first)
            req[seq_idx] <= 1'b0;
        end
        default:
          req <= '0;
      endcase
    end
  end

  // simultaneity window after each rise of an enable pin
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      win_cnt   <= '0;
      win_rails <= '0;
      grouped   <= '0;
    end
    else if (!host_ctl)
    begin
      win_cnt   <= '0;
      win_rails <= '0;
      grouped   <= '0;
    end
    else
    begin
      if (|en_rise)
      begin
        win_cnt   <= CNT_W'(WIN_CYCLES);
        win_rails <= (win_cnt != '0) ? (win_rails | en_rise) : en_rise;
      end
      else if (win_cnt != '0)
        win_cnt <= win_cnt - 1'b1;
      else
        win_rails <= '0;
      if ((|en_rise && win_cnt != '0) || $countones(en_rise) > 1)
        grouped <= (grouped | en_rise | win_rails) & (req | en_rise);
      else
        grouped <= grouped & req;
    end
  end

  // rail enables with the internal power-good gating
  always_comb
  begin
    for (int unsigned i = 0; i < NUM_RAILS; i++)
    begin
      next_rail_en[i] = req[i] && pos_en && POS_BOOST_PG_I;
      if (i == RAIL_PSRC && !rail_reg[RAIL_NSRC])
        next_rail_en[i] = 1'b0;
      if (grouped[i] && !rail_en[i] && !stagger_ok(i, grouped, req, rail_reg))
        next_rail_en[i] = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      rail_en <= '0;
    else
      rail_en <= next_rail_en;
  end

  // a rail regulates a fixed time after its enable
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      rail_reg <= '0;
      for (int unsigned i = 0; i < NUM_RAILS; i++)
        rail_cnt[i] <= '0;
    end
    else
    begin
      for (int unsigned i = 0; i < NUM_RAILS; i++)
      begin
        if (!rail_en[i])
        begin
          rail_cnt[i] <= '0;
          rail_reg[i] <= 1'b0;
        end
        else
        begin
          if (rail_cnt[i] != CNT_W'(RAIL_CYCLES - 1))
            rail_cnt[i] <= rail_cnt[i] + 1'b1;
          rail_reg[i] <= (rail_cnt[i] == CNT_W'(RAIL_CYCLES - 1)) && !RAIL_UV_I[i];
        end
      end
    end
  end

  // base converters start when any rail is wanted
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      inv_en <= 1'b0;
      pos_en <= 1'b0;
    end
    else
    begin
      inv_en <= (state == ST_ACTIVE || state == ST_PWRUP || state == ST_PWRDN) && |req && !base_fault;
      pos_en <= inv_en && INV_CONV_PG_I && !base_fault;
    end
  end

  // soft-start watchdog on both base converters
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      soft_cnt <= '0;
    else if (!inv_en || (INV_CONV_PG_I && POS_BOOST_PG_I))
      soft_cnt <= '0;
    else if (!soft_abort)
      soft_cnt <= soft_cnt + 1'b1;
  end

  // registered outputs
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      SUPPORT_ON_O    <= 1'b0;
      MODE_O          <= MODE_SLEEP;
      RAILS_OK_OE_N_O <= 1'b0;
    end
    else
    begin
      SUPPORT_ON_O    <= (state != ST_SLEEP);
      // next enables, so the pin drops in the same cycle as a rail
      RAILS_OK_OE_N_O <= (&rail_reg) && (&next_rail_en) && !base_fault;
      case (state)
        ST_SLEEP:   MODE_O <= MODE_SLEEP;
        ST_STANDBY: MODE_O <= MODE_STANDBY;
        default:    MODE_O <= MODE_ACTIVE;
      endcase
    end
  end

  assign INV_CONV_EN_O  = inv_en;
  assign POS_BOOST_EN_O = pos_en;
  assign RAIL_EN_O      = rail_en;
  assign BIAS_EN_O      = rail_en[RAIL_NSRC];
  assign RAILS_OK_O     = 1'b0;

endmodule

/* File: tb/dps_seq_asserts.sv */
// port checker for the rail power sequencer
`timescale 1ns/1ps
module dps_seq_asserts
  import dps_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 20,
  parameter int unsigned RAIL_CYCLES = 20,
  parameter int unsigned SOFT_CYCLES = 100,
  parameter int unsigned WIN_CYCLES  = 10
) (
  input wire logic                          MCLK_I,             // clock
  input wire logic                          RST_I,              // reset
  input wire logic                          WAKE_PIN_I,         // wake
  input wire logic [dps_pkg::NUM_RAILS-1:0] RAIL_ENABLE_PINS_I, // pins
  input wire logic                          INPUT_INPUT_UNDERVOLTAGE_LOCKOUT_I,       // fault
  input wire logic                          POS_BOOST_UV_I,     // fault
  input wire logic                          INV_CONV_UV_I,      // fault
  input wire logic                          THERMAL_SHUTDOWN_I, // fault
  input wire logic [dps_pkg::NUM_RAILS-1:0] RAIL_UV_I,          // rail uv
  input wire logic                          INV_CONV_PG_I,      // good
  input wire logic                          POS_BOOST_PG_I,     // good
  input wire logic                          INV_CONV_EN_O,      // enable
  input wire logic                          POS_BOOST_EN_O,     // enable
  input wire logic [dps_pkg::NUM_RAILS-1:0] RAIL_EN_O,          // rails
  input wire logic                          BIAS_EN_O,          // bias
  input wire logic                          SUPPORT_ON_O,       // support
  input wire logic [1:0]                    MODE_O,             // mode
  input wire logic                          RAILS_OK_O,         // od data
  input wire logic                          RAILS_OK_OE_N_O     // od enable
);
  localparam int FLT_MAX = 4 * STEP_CYCLES + 20;
  logic             flt_any;
  logic [CNT_W-1:0] on0_cnt;
  logic [CNT_W-1:0] all_cnt;
  logic [CNT_W-1:0] soft_cnt;
  assign flt_any = INPUT_INPUT_UNDERVOLTAGE_LOCKOUT_I || POS_BOOST_UV_I || INV_CONV_UV_I || THERMAL_SHUTDOWN_I;
  always_ff @(posedge MCLK_I)
  begin
    on0_cnt <= (RST_I || !RAIL_EN_O[0]) ? '0 : on0_cnt + 1'b1;
    all_cnt <= (RST_I || !(&RAIL_EN_O) || RAIL_UV_I != '0 || flt_any) ? '0 : all_cnt + 1'b1;
    soft_cnt <= (RST_I || !INV_CONV_EN_O || (INV_CONV_PG_I && POS_BOOST_PG_I)) ? '0 : soft_cnt + 1'b1;
  end
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  AST_SLEEP_OFF: assert property (MODE_O == MODE_SLEEP |-> RAIL_EN_O == '0 && !SUPPORT_ON_O)
    else $error("rail or support on in sleep");
  AST_STBY_OFF: assert property (MODE_O == MODE_STANDBY |-> RAIL_EN_O == '0 && SUPPORT_ON_O)
    else $error("rail on in standby");
  AST_BOOST_GATE: assert property ($rose(POS_BOOST_EN_O) |-> $past(INV_CONV_PG_I))
    else $error("boost enabled before inverting good");
  AST_RAIL_GATE: assert property ((RAIL_EN_O & ~$past(RAIL_EN_O)) != '0 |-> $past(POS_BOOST_PG_I))
    else $error("rail enabled without boost good");
  AST_BIAS: assert property (BIAS_EN_O == RAIL_EN_O[0])
    else $error("bias not with negative source");
  AST_PSRC_WAIT: assert property ($rose(RAIL_EN_O[2]) |-> $past(on0_cnt) >= RAIL_CYCLES - 1)
    else $error("positive source before negative source good");
  AST_OK_ONLY_ALL: assert property (RAILS_OK_OE_N_O |-> &RAIL_EN_O && RAILS_OK_O == 1'b0)
    else $error("good released with a rail off");
  AST_OK_AFTER_REG: assert property ($rose(RAILS_OK_OE_N_O) |-> all_cnt >= RAIL_CYCLES)
    else $error("good released before regulation");
  AST_OK_RISE: assert property (all_cnt == RAIL_CYCLES + 6 |-> RAILS_OK_OE_N_O)
    else $error("good not released");
  AST_FAULT_STBY: assert property ($rose(flt_any) && MODE_O == MODE_ACTIVE |-> ##[1:FLT_MAX] MODE_O == MODE_STANDBY)
    else $error("fault did not reach standby");
  AST_SOFT_ABORT: assert property (soft_cnt == SOFT_CYCLES - 2 |-> ##[1:FLT_MAX] MODE_O == MODE_STANDBY)
    else $error("soft start not aborted");
  AST_PIN_FALL: assert property ($fell(RAIL_ENABLE_PINS_I[1]) && MODE_O == MODE_ACTIVE |-> ##[1:6] !RAIL_EN_O[1])
    else $error("rail kept after pin fall");
endmodule
bind dps_sequencer dps_seq_asserts #(
  .STEP_CYCLES(STEP_CYCLES), .RAIL_CYCLES(RAIL_CYCLES), .SOFT_CYCLES(SOFT_CYCLES), .WIN_CYCLES(WIN_CYCLES)
) chk_u (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .WAKE_PIN_I(WAKE_PIN_I), .RAIL_ENABLE_PINS_I(RAIL_ENABLE_PINS_I),
  .INPUT_INPUT_UNDERVOLTAGE_LOCKOUT_I(INPUT_INPUT_UNDERVOLTAGE_LOCKOUT_I), .POS_BOOST_UV_I(POS_BOOST_UV_I), .INV_CONV_UV_I(INV_CONV_UV_I),
  .THERMAL_SHUTDOWN_I(THERMAL_SHUTDOWN_I), .RAIL_UV_I(RAIL_UV_I), .INV_CONV_PG_I(INV_CONV_PG_I),
  .POS_BOOST_PG_I(POS_BOOST_PG_I), .INV_CONV_EN_O(INV_CONV_EN_O), .POS_BOOST_EN_O(POS_BOOST_EN_O),
  .RAIL_EN_O(RAIL_EN_O), .BIAS_EN_O(BIAS_EN_O), .SUPPORT_ON_O(SUPPORT_ON_O), .MODE_O(MODE_O),
  .RAILS_OK_O(RAILS_OK_O), .RAILS_OK_OE_N_O(RAILS_OK_OE_N_O)
);

/* File: tb/dps_conv_model.sv */
// base converter model answering enables with power-good
`timescale 1ns/1ps
module dps_conv_model #(
  parameter int unsigned DLY = 3
) (
  input  wire logic clk_i,    // clock
  input  wire logic inv_en_i, // inverting enable
  input  wire logic bst_en_i, // boost enable
  input  wire logic stall_i,  // never reach good
  output logic      inv_pg_o, // inverting good
  output logic      bst_pg_o  // boost good
);
  logic [3:0] inv_t;
  logic [3:0] bst_t;
  always_ff @(posedge clk_i)
  begin
    inv_t <= inv_en_i ? inv_t + (inv_t < DLY) : 4'h0;
    bst_t <= bst_en_i ? bst_t + (bst_t < DLY) : 4'h0;
  end
  // good drops at once when disabled
  assign inv_pg_o = inv_en_i && !stall_i && inv_t >= DLY;
  assign bst_pg_o = bst_en_i && !stall_i && bst_t >= DLY;
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the rail power sequencer
`timescale 1ns/1ps
module tb_top;
  import dps_pkg::*;
  localparam int STEP_C = 20;
  localparam int RAIL_C = 20;
  localparam int SOFT_C = 100;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wake = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [3:0] flt = 4'h0;
  logic [3:0] ruv = 4'h0;
  logic       stall = 1'b0;
  logic       inv_en, bst_en, inv_pg, bst_pg, bias, sup, ok, ok_oe_n;
  logic [3:0] ren;
  logic [3:0] ren_d;
  logic [1:0] mode;
  int         failures = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         t_on [4];
  int         t_off [4];
  int         ord [4] = '{0, 1, 2, 3};
  initial
  begin
    forever #5 clk = ~clk;
  end
  dps_sequencer #(.STEP_CYCLES(STEP_C), .RAIL_CYCLES(RAIL_C), .SOFT_CYCLES(SOFT_C), .WIN_CYCLES(10)) dut_u (
    .MCLK_I(clk), .RST_I(rst), .WAKE_PIN_I(wake), .RAIL_ENABLE_PINS_I(pins), .INPUT_INPUT_UNDERVOLTAGE_LOCKOUT_I(flt[0]),
    .POS_BOOST_UV_I(flt[1]), .INV_CONV_UV_I(flt[2]), .THERMAL_SHUTDOWN_I(flt[3]), .RAIL_UV_I(ruv),
    .INV_CONV_PG_I(inv_pg), .POS_BOOST_PG_I(bst_pg), .INV_CONV_EN_O(inv_en), .POS_BOOST_EN_O(bst_en),
    .RAIL_EN_O(ren), .BIAS_EN_O(bias), .SUPPORT_ON_O(sup), .MODE_O(mode), .RAILS_OK_O(ok),
    .RAILS_OK_OE_N_O(ok_oe_n));
  dps_conv_model conv_u (.clk_i(clk), .inv_en_i(inv_en), .bst_en_i(bst_en), .stall_i(stall),
    .inv_pg_o(inv_pg), .bst_pg_o(bst_pg));
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ren_d <= ren;
    for (int i = 0; i < 4; i++)
    begin
      if (ren[i] && !ren_d[i]) t_on[i] <= cyc;
      if (!ren[i] && ren_d[i]) t_off[i] <= cyc;
    end
    if (cyc == 5000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic good, input string msg);
    tests_run++;
    if (good !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk) pins <= v;
  endtask
  task automatic shuffle();
    int j;
    int t;
    for (int i = 3; i > 0; i--)
    begin
      j = $urandom % (i + 1);
      t = ord[i];
      ord[i] = ord[j];
      ord[j] = t;
    end
  endtask
  // positive source cannot start before negative source
  function automatic int rank(int r);
    int p [4];
    for (int i = 0; i < 4; i++) p[ord[i]] = 2 * i;
    if (r == RAIL_PSRC && p[RAIL_PSRC] < p[RAIL_NSRC]) return p[RAIL_NSRC] + 1;
    return p[r];
  endfunction
  initial
  begin
    void'($urandom(9254));
    tick(16);
    rst <= 1'b0;
    tick(2);
    chk(mode === MODE_SLEEP && ok_oe_n === 1'b0 && ok === 1'b0, "reset state");
    @(posedge clk) wake <= 1'b1;
    tick(8);
    chk(mode === MODE_STANDBY && sup === 1'b1 && ren === 4'h0, "standby");
    shuffle();
    for (int i = 0; i < 4; i++)
    begin
      set_pins(pins | (4'h1 << ord[i]));
      tick(50);
    end
    for (int a = 0; a < 4; a++)
      for (int b = 0; b < 4; b++)
        if (rank(a) < rank(b)) chk(t_on[a] < t_on[b], "host power-up order");
    chk(mode === MODE_ACTIVE && ok_oe_n === 1'b1 && bias === 1'b1, "all rails good");
    shuffle();
    for (int i = 0; i < 4; i++)
    begin
      set_pins(pins & ~(4'h1 << ord[i]));
      tick(8);
      chk(ren[ord[i]] === 1'b0 && ((ren ^ pins) & 4'hb) === 4'h0, "host power-down order");
      chk(ok_oe_n === 1'b0, "good pulled low");
    end
    tick(10);
    chk(mode === MODE_STANDBY, "standby after all off");
    set_pins(4'hf);
    tick(120);
    for (int r = 0; r < 3; r++) chk(t_on[r] < t_on[r + 1], "default stagger");
    set_pins(4'h0);
    tick(10);
    chk(t_off[0] == t_off[1] && t_off[1] == t_off[2] && t_off[2] == t_off[3], "joint off");
    tick(10);
    @(posedge clk) wake <= 1'b0;
    tick(8);
    chk(mode === MODE_SLEEP && sup === 1'b0, "standby to sleep");
    set_pins(4'hf);
    tick(4);
    @(posedge clk) wake <= 1'b1;
    tick(6 * STEP_C);
    chk(mode === MODE_ACTIVE && ren === 4'hf, "wake power-up");
    for (int r = 0; r < 3; r++) chk(t_on[r] < t_on[r + 1], "fixed power-up order");
    @(posedge clk) wake <= 1'b0;
    tick(6 * STEP_C);
    for (int r = 0; r < 3; r++) chk(t_off[r] - t_off[r + 1] == STEP_C, "power-down step");
    chk(mode === MODE_SLEEP, "wake fall to sleep");
    @(posedge clk) wake <= 1'b1;
    tick(6 * STEP_C);
    @(posedge clk) flt[$urandom % 4] <= 1'b1;
    tick(6 * STEP_C);
    chk(mode === MODE_STANDBY && ren === 4'h0 && ok_oe_n === 1'b0, "fault to standby");
    @(posedge clk) flt <= 4'h0;
    set_pins(4'h0);
    @(posedge clk) stall <= 1'b1;
    set_pins(4'h1);
    tick(SOFT_C + 6 * STEP_C);
    chk(mode === MODE_STANDBY && ren === 4'h0, "soft-start abort");
    @(posedge clk) stall <= 1'b0;
    set_pins(4'h0);
    tick(4);
    set_pins(4'hf);
    tick(120);
    @(posedge clk) ruv[RAIL_NGATE] <= 1'b1;
    tick(8);
    chk(mode === MODE_ACTIVE && ren === 4'hd && ok_oe_n === 1'b0, "rail undervoltage");
    end_sim();
  end
endmodule
